// *** rsbt_host.sv ***
`timescale 1ns/100ps
module rsbt_host #(
  parameter int AXI_ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output rsbt_pkg::rsbt_pins_t dramPins,
  output logic [7:0] maskDataOut,
  output logic maskDataOe,
  input wire logic [7:0] maskDataIn,
  input wire logic halfActiveFlag
);
  if (AXI_ADDR_W < 4 || AXI_ADDR_W > 32) begin : g_bad_width
    $error("AXI_ADDR_W must lie between 4 and 32.");
  end

  typedef enum {
    S_IDLE, S_SETUP, S_RAS, S_COL, S_CAS, S_DTWAIT, S_RASHI, S_PRE, S_HOLD
  } rsbt_state_t;

  // Byte-lane merge of a register write.
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  rsbt_state_t state_r, stateNxt;
  logic [7:0] cnt_r, cntNxt;
  logic bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, addrReg_r, maskReg_r;
  rsbt_pkg::rsbt_kind_t kind_r, runKind_r;
  logic scRun_r, pending_r, refused_r, normalDone_r, portOut_r, lastWrite_r;
  logic qsfMeta_r, qsfSync_r, qsfLast_r;
  logic [7:0] ioMeta_r, ioSync_r;
  logic [7:0] qsfAge_r;
  logic [7:0] scCnt_r;
  logic scLevel_r;
  logic rasN_r, casN_r, dtN_r, weN_r, sfs_r, maskOe_r;
  logic [8:0] pinAddr_r;
  logic [7:0] maskOut_r;

  // Write channel: address and data are taken together, one write at a time.
  wire awTake = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  wire [7:0] wAddr = 8'(s_axi_awaddr);
  wire [7:0] rAddr = 8'(s_axi_araddr);
  wire wrCtrl = awTake && (wAddr == rsbt_pkg::REG_CTRL);
  wire wrAddr = awTake && (wAddr == rsbt_pkg::REG_ADDR);
  wire wrMask = awTake && (wAddr == rsbt_pkg::REG_MASK);
  wire wrKnown = wrCtrl || wrAddr || wrMask || (wAddr == rsbt_pkg::REG_STATUS);
  wire goPulse = wrCtrl && s_axi_wstrb[0] && s_axi_wdata[rsbt_pkg::CTRL_GO];
  wire arTake = s_axi_arvalid && !rvalid_r;
  assign s_axi_awready = awTake;
  assign s_axi_wready = awTake;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // Status word and read decode.
  wire busy = (state_r != S_IDLE) || pending_r;
  wire [31:0] statusWord = {16'h0000, ioSync_r, 2'h0, lastWrite_r, normalDone_r,
                            portOut_r, qsfSync_r, refused_r, busy};
  wire [31:0] ctrlWord = {28'h0000000, scRun_r, kind_r, 1'b0};
  wire rdKnown = (rAddr == rsbt_pkg::REG_CTRL) || (rAddr == rsbt_pkg::REG_ADDR) ||
                 (rAddr == rsbt_pkg::REG_MASK) || (rAddr == rsbt_pkg::REG_STATUS);
  wire [31:0] rdWord = (rAddr == rsbt_pkg::REG_CTRL) ? ctrlWord :
                       (rAddr == rsbt_pkg::REG_ADDR) ? addrReg_r :
                       (rAddr == rsbt_pkg::REG_MASK) ? maskReg_r :
                       (rAddr == rsbt_pkg::REG_STATUS) ? statusWord : 32'h00000000;

  // Bus responses.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bvalid_r <= 1'b0;
      bresp_r <= rsbt_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= rsbt_pkg::RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else begin
      if (awTake) begin
        bvalid_r <= 1'b1;
        bresp_r <= wrKnown ? rsbt_pkg::RESP_OKAY : rsbt_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (arTake) begin
        rvalid_r <= 1'b1;
        rresp_r <= rdKnown ? rsbt_pkg::RESP_OKAY : rsbt_pkg::RESP_SLVERR;
        rdata_r <= rdWord;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Software registers.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      addrReg_r <= 32'h00000000;
      maskReg_r <= 32'h00000000;
      kind_r <= rsbt_pkg::RSBT_READ;
      scRun_r <= 1'b0;
    end else begin
      if (wrAddr) addrReg_r <= merge(addrReg_r, s_axi_wdata, s_axi_wstrb) & 32'h01FF01FF;
      if (wrMask) maskReg_r <= merge(maskReg_r, s_axi_wdata, s_axi_wstrb) & 32'h000000FF;
      if (wrCtrl && s_axi_wstrb[0]) begin
        kind_r <= rsbt_pkg::rsbt_kind_t'(s_axi_wdata[rsbt_pkg::CTRL_KIND +: 2]);
        scRun_r <= s_axi_wdata[rsbt_pkg::CTRL_SCRUN];
      end
    end
  end

  // Half flag and lane inputs pass two flip-flops; age counts cycles since a flag toggle.
  wire qsfToggle = qsfSync_r ^ qsfLast_r;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      qsfMeta_r <= 1'b0;
      qsfSync_r <= 1'b0;
      qsfLast_r <= 1'b0;
      ioMeta_r <= 8'h00;
      ioSync_r <= 8'h00;
      qsfAge_r <= 8'(rsbt_pkg::WINDOW_CYC);
    end else begin
      qsfMeta_r <= halfActiveFlag;
      qsfSync_r <= qsfMeta_r;
      qsfLast_r <= qsfSync_r;
      ioMeta_r <= maskDataIn;
      ioSync_r <= ioMeta_r;
      if (qsfToggle) qsfAge_r <= 8'h00;
      else if (qsfAge_r < 8'(rsbt_pkg::WINDOW_CYC)) qsfAge_r <= qsfAge_r + 8'h01;
    end
  end

  // Start conditions for a queued transfer.
  wire isSplit = kind_r[1];
  wire windowOk = isSplit ? (qsfAge_r >= 8'(rsbt_pkg::WINDOW_CYC)) // RL20
                          : (qsfAge_r >= 8'(rsbt_pkg::STS_CYC)); // RL21
  // A split write also needs the port turned to input by a write transfer first.
  wire splitRefused = isSplit && (!normalDone_r || (kind_r[0] && portOut_r)); // RL14 RL17
  wire startNow = (state_r == S_IDLE) && pending_r && windowOk && !splitRefused;

  // Serial clock is held static through normal write transfers and reads after a write.
  wire holdSc = (state_r != S_IDLE) &&
                (runKind_r == rsbt_pkg::RSBT_WRITE ||
                 (runKind_r == rsbt_pkg::RSBT_READ && lastWrite_r)); // RL7 RL12
  wire scEn = scRun_r && !holdSc;
  wire scEdge = scEn && (scCnt_r == 8'(rsbt_pkg::SC_HALF_CYC - 1));
  wire scFallNow = scEdge && scLevel_r;
  wire realTime = (runKind_r == rsbt_pkg::RSBT_READ) && scEn;

  // Sequencer next state: row address, row fall, column address, column fall, release.
  always_comb begin
    stateNxt = state_r;
    case (state_r)
      S_IDLE: if (startNow) stateNxt = S_SETUP;
      S_SETUP: if (cnt_r == 8'h00) stateNxt = S_RAS;
      S_RAS: if (cnt_r == 8'h00) stateNxt = S_COL;
      S_COL: if (cnt_r == 8'h00) stateNxt = S_CAS; // RL18
      S_CAS: if (cnt_r == 8'h00) stateNxt = S_DTWAIT;
      S_DTWAIT: if (!realTime || scFallNow) stateNxt = S_RASHI; // RL6
      S_RASHI: if (cnt_r == 8'h00) stateNxt = S_PRE;
      S_PRE: if (cnt_r == 8'h00) stateNxt = S_HOLD;
      S_HOLD: if (cnt_r == 8'h00) stateNxt = S_IDLE;
      default: stateNxt = S_IDLE;
    endcase
  end

  // Dwell of each state; the hold after a normal write transfer, or a read after a write, keeps the serial clock still.
  wire [7:0] holdLen = (runKind_r == rsbt_pkg::RSBT_WRITE) ? 8'(rsbt_pkg::SRD_CYC - 1)
                                                           : 8'(rsbt_pkg::TSD_CYC - 1);
  wire [7:0] lenNxt = (stateNxt == S_CAS) ? 8'(rsbt_pkg::CAS_LOW_CYC - 1) :
                      (stateNxt == S_RASHI) ? 8'(rsbt_pkg::RAS_LOW_CYC - 1) :
                      (stateNxt == S_PRE) ? 8'(rsbt_pkg::PRECHARGE_CYC - 1) :
                      (stateNxt == S_HOLD) ? holdLen : 8'(rsbt_pkg::ADDR_SETUP_CYC - 1);
  assign cntNxt = (stateNxt != state_r) ? lenNxt : ((cnt_r == 8'h00) ? 8'h00 : cnt_r - 8'h01);

  // Pin levels for the next cycle; the column strobe only falls after the row strobe, so no
  // refresh cycle is ever issued that could move a serial boundary.
  wire rasLowNxt = (stateNxt inside {S_RAS, S_COL, S_CAS, S_DTWAIT, S_RASHI});
  wire casLowNxt = (stateNxt inside {S_CAS, S_DTWAIT, S_RASHI}); // RL22
  wire dtLowNxt = (stateNxt inside {S_SETUP, S_RAS, S_COL, S_CAS, S_DTWAIT});
  wire colNxt = (stateNxt inside {S_COL, S_CAS, S_DTWAIT, S_RASHI});
  wire [1:0] kindNxt = startNow ? kind_r : runKind_r;
  wire maskOeNxt = kindNxt[0] && (stateNxt inside {S_SETUP, S_RAS}); // RL10 RL11

  // Sequencer and transfer bookkeeping.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_r <= S_IDLE;
      cnt_r <= 8'h00;
      runKind_r <= rsbt_pkg::RSBT_READ;
      pending_r <= 1'b0;
      refused_r <= 1'b0;
      normalDone_r <= 1'b0;
      portOut_r <= 1'b0;
      lastWrite_r <= 1'b0;
    end else begin
      state_r <= stateNxt;
      cnt_r <= cntNxt;
      if (startNow) runKind_r <= kind_r;
      if (goPulse && !busy) pending_r <= 1'b1;
      else if (startNow || (state_r == S_IDLE && pending_r && splitRefused)) pending_r <= 1'b0;
      if ((goPulse && busy) || (state_r == S_IDLE && pending_r && splitRefused)) begin
        refused_r <= 1'b1;
      end else if (wrCtrl && s_axi_wstrb[0] && !s_axi_wdata[rsbt_pkg::CTRL_GO]) begin
        refused_r <= 1'b0;
      end
      if (state_r == S_HOLD && stateNxt == S_IDLE) begin
        lastWrite_r <= runKind_r[0];
        if (!runKind_r[1]) begin
          normalDone_r <= 1'b1;
          portOut_r <= !runKind_r[0]; // RL23
        end
      end
    end
  end

  // Registered pins; the serial clock comes from a divider of the system clock.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rasN_r <= 1'b1;
      casN_r <= 1'b1;
      dtN_r <= 1'b1;
      weN_r <= 1'b1;
      sfs_r <= 1'b0;
      pinAddr_r <= 9'h000;
      maskOe_r <= 1'b0;
      maskOut_r <= 8'h00;
      scCnt_r <= 8'h00;
      scLevel_r <= 1'b0;
    end else begin
      rasN_r <= !rasLowNxt;
      casN_r <= !casLowNxt;
      dtN_r <= !dtLowNxt;
      weN_r <= !kindNxt[0]; // RL1
      sfs_r <= kindNxt[1]; // RL1
      pinAddr_r <= colNxt ? addrReg_r[rsbt_pkg::ADDR_COL +: 9] : addrReg_r[8:0];
      maskOe_r <= maskOeNxt;
      maskOut_r <= maskReg_r[7:0];
      scCnt_r <= (!scEn || scEdge) ? 8'h00 : scCnt_r + 8'h01;
      if (scEdge) scLevel_r <= !scLevel_r;
    end
  end

  assign dramPins = '{rasN: rasN_r, casN: casN_r, transferOutputEnableN: dtN_r,
                      writeMaskWriteEnableN: weN_r, specialFunctionSelect: sfs_r,
                      serialClock: scLevel_r, addr: pinAddr_r};
  assign maskDataOut = maskOut_r;
  assign maskDataOe = maskOe_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence rasFall;
    $fell(dramPins.rasN);
  endsequence
  sequence casFallSoon;
    ##[1:8] $fell(dramPins.casN);
  endsequence

  chk_cas_after_ras: assert property (rasFall |-> casFallSoon) // RL18
    else $error("Column strobe did not fall after row strobe fall.");
  chk_mode_at_ras: assert property (rasFall |-> dramPins.casN && // RL1
      !dramPins.transferOutputEnableN &&
      dramPins.writeMaskWriteEnableN == !runKind_r[0] &&
      dramPins.specialFunctionSelect == runKind_r[1])
    else $error("Transfer mode levels wrong at row strobe fall.");
  chk_mask_at_ras: assert property ((rasFall and runKind_r[0]) |-> maskDataOe) // RL10
    else $error("Mask lines not driven at row fall of a write transfer.");
  chk_sc_static: assert property (holdSc && $past(holdSc) |-> $stable(dramPins.serialClock)) // RL12
    else $error("Serial clock moved while it must stay static.");
  chk_split_prior: assert property (startNow && kind_r[1] |-> normalDone_r) // RL14
    else $error("Split transfer started without a prior normal transfer.");
  chk_split_wr_prior: assert property (startNow && kind_r == rsbt_pkg::RSBT_SPLIT_WRITE |-> // RL17
      normalDone_r && !portOut_r)
    else $error("Split write started while the serial port was not in input mode.");
  chk_split_window: assert property (startNow && kind_r[1] |->
      qsfAge_r >= 8'(rsbt_pkg::WINDOW_CYC)) // RL20
    else $error("Split transfer started inside the forbidden window.");
  chk_normal_setup: assert property (startNow && !kind_r[1] |->
      qsfAge_r >= 8'(rsbt_pkg::STS_CYC)) // RL21
    else $error("Normal transfer started too soon after half flag toggle.");
  chk_realtime_dt: assert property ($rose(dramPins.transferOutputEnableN) &&
      $past(realTime) |-> $fell(dramPins.serialClock)) // RL6
    else $error("Real-time read release not on a serial clock fall.");
  chk_port_dir: assert property (state_r == S_HOLD && stateNxt == S_IDLE && !runKind_r[1]
      |=> portOut_r == !runKind_r[0]) // RL9
    else $error("Serial port direction not updated after normal transfer.");
endmodule

// *** rsbt_pkg.sv ***
// Functional notes
// RL1: Transfer selected at row strobe fall: column high, output enable low, mode pins.
// RL2: Normal transfer moves a full 512-word row either direction.
// RL3: Split transfer moves 256 words between matching halves.
// RL4: Read transfer copies the row into the buffer; serial port becomes output.
// RL5: Read transfer loads start pointer from column address at column fall.
// RL6: Real-time read places output enable rise on a serial clock fall.
// RL7: Read after write keeps serial clock static until transfer delay passes.
// RL8: Write transfer stores buffer into row; start pointer from column address.
// RL9: After write transfer the serial pins turn to input.
// RL10: Write transfers are masked per lane by mask lines at row fall.
// RL11: Turning port to input needs a fully masked write transfer; the host drives maskReg_r as set and clears portOut_r only after a normal write transfer.
// RL12: Back-to-back writes keep serial clock static until delay after row rise.
// RL13: Split read reloads standby half; half chosen internally, no clock sync.
// RL14: A normal transfer must precede any split read.
// RL15: Device toggles half flag when active half's last clock arrives.
// RL16: Split write stores standby half while the other half takes input.
// RL17: A write transfer must precede any split write.
// RL18: Never run a transfer with the column strobe held high throughout.
// RL19: Last split into one half before flag toggle sets the pointer.
// RL20: No split transfer inside the hold plus setup window around switchover.
// RL21: Normal transfer after splits waits setup window after flag toggle.
// RL22: Avoid boundary changes while pointer sits on a boundary's last address.
// RL23: Split transfers leave serial port direction unchanged.
// RL24: Serial pointer advances one word per serial clock rise.
// RL25: Refresh option reset returns masking to new mask mode.
package rsbt_pkg;
  localparam int CLK_NS = 8;
  localparam int ADDR_SETUP_NS = 16;
  localparam int RAS_LOW_NS = 80;
  localparam int CAS_LOW_NS = 24;
  localparam int PRECHARGE_NS = 64;
  localparam int SC_HALF_NS = 40;
  localparam int SC_AFTER_TRANSFER_NS = 40;
  localparam int SC_AFTER_WRITE_NS = 24;
  localparam int SPLIT_HOLD_NS = 24;
  localparam int SPLIT_SETUP_NS = 24;

  // Least times round up to whole clock cycles, never below one.
  function automatic int cycles(int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ADDR_SETUP_CYC = cycles(ADDR_SETUP_NS);
  localparam int RAS_LOW_CYC = cycles(RAS_LOW_NS);
  localparam int CAS_LOW_CYC = cycles(CAS_LOW_NS);
  localparam int PRECHARGE_CYC = cycles(PRECHARGE_NS);
  localparam int SC_HALF_CYC = cycles(SC_HALF_NS);
  localparam int TSD_CYC = cycles(SC_AFTER_TRANSFER_NS);
  localparam int SRD_CYC = cycles(SC_AFTER_WRITE_NS);
  localparam int STS_CYC = cycles(SPLIT_SETUP_NS);
  localparam int WINDOW_CYC = cycles(SPLIT_HOLD_NS) + STS_CYC;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CTRL_GO = 0;
  localparam int CTRL_KIND = 1;
  localparam int CTRL_SCRUN = 3;
  localparam int ADDR_COL = 16;
  localparam int STAT_IO = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bit 0 of a kind means write, bit 1 means split.
  typedef enum logic [1:0] {
    RSBT_READ, RSBT_WRITE, RSBT_SPLIT_READ, RSBT_SPLIT_WRITE
  } rsbt_kind_t;

  typedef struct packed {
    logic rasN;
    logic casN;
    logic transferOutputEnableN;
    logic writeMaskWriteEnableN;
    logic specialFunctionSelect;
    logic serialClock;
    logic [8:0] addr;
  } rsbt_pins_t;
endpackage

// *** rsbt_dev_model.sv ***
`timescale 1ns/100ps
module rsbt_dev_model (
  input wire rsbt_pkg::rsbt_pins_t pins,
  input wire logic [7:0] maskDataOut,
  input wire logic maskDataOe,
  output logic [7:0] maskDataIn,
  output logic halfActiveFlag
);
  logic [1:0] kind = 2'h0;
  logic [8:0] row = 9'h000, col = 9'h000, ptr = 9'h000, tap = 9'h000;
  logic [7:0] mask = 8'h00, lastLvl = 8'h00;
  logic portOut = 1'h0, prevWrite = 1'h0, inXfer = 1'h0, tapSet = 1'h0;
  int count = 0, words = 0, scBad = 0;

  // Released data lines show the inverse of the last driven level.
  assign maskDataIn = maskDataOe ? maskDataOut : ~lastLvl;
  always @(maskDataOut or maskDataOe) if (maskDataOe) lastLvl = maskDataOut;

  // The row strobe fall decodes a transfer and latches the row, and the mask for a write.
  always @(negedge pins.rasN) begin
    inXfer = pins.casN && !pins.transferOutputEnableN;
    if (inXfer) begin
      kind = {pins.specialFunctionSelect, !pins.writeMaskWriteEnableN};
      row = pins.addr;
      words = kind[1] ? 256 : 512;
      if (kind[0]) mask = maskDataOut;
      count++;
    end
  end

  // The column strobe fall sets the start pointer (the tap for a split) and, for a normal transfer, the port direction.
  always @(negedge pins.casN) if (inXfer) begin
    col = pins.addr;
    if (!kind[1]) begin
      ptr = pins.addr;
      tapSet = 1'h0;
    end else begin
      tap = pins.addr;
      tapSet = 1'h1;
    end
    if (kind == 2'h0) portOut = 1'h1;
    else if (kind == 2'h1) portOut = 1'h0;
  end

  // The row strobe rise ends the cycle.
  always @(posedge pins.rasN) if (inXfer) begin
    prevWrite = kind[0];
    inXfer = 1'h0;
  end

  // Each serial clock rise moves the pointer; a finished half flips the flag.
  always @(posedge pins.serialClock) begin
    if (inXfer && (kind[0] || prevWrite)) scBad++;
    ptr = ptr + 9'h001;
    if (ptr[7:0] == 8'h00) begin
      halfActiveFlag = ~halfActiveFlag;
      if (tapSet) ptr[7:0] = tap[7:0];
      tapSet = 1'h0;
    end
  end

  // A real-time read must end its output enable where the serial clock falls.
  always @(posedge pins.transferOutputEnableN) #1 begin
    if (inXfer && kind == 2'h0 && !prevWrite && pins.serialClock) scBad++;
  end

  initial halfActiveFlag = 1'h0;
endmodule

// *** row_serial_buffer_transfer_tb_top.sv ***
`timescale 1ns/100ps
module row_serial_buffer_transfer_tb_top;
  typedef struct packed {logic [31:0] val; logic [31:0] msk; logic [1:0] resp;} rsbt_note_t;
  logic sys_clk = 1'h0, rstn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, m, lineOut, lineIn, lvl = 8'hFF;
  logic [31:0] wdata = 32'h0, rs = 32'h00012B96, d, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [8:0] row, col;
  logic awready, wready, bvalid, arready, rvalid, halfFlag, lineOe, port;
  logic [1:0] bresp, rresp;
  rsbt_pkg::rsbt_pins_t pins;
  rsbt_note_t note, rq[$];
  logic [1:0] bq[$];
  int n_mismatch = 0, tests_run = 0;

  always #4 sys_clk = ~sys_clk;

  rsbt_host uut (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1), .dramPins(pins),
    .maskDataOut(lineOut), .maskDataOe(lineOe), .maskDataIn(lineIn), .halfActiveFlag(halfFlag));
  rsbt_dev_model dev (.pins(pins), .maskDataOut(lineOut), .maskDataOe(lineOe),
    .maskDataIn(lineIn), .halfActiveFlag(halfFlag));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Responses are compared against the oldest note left by the driver.
  always @(posedge sys_clk) begin
    if (rvalid) begin
      note = rq.pop_front();
      check("read data", note.val & note.msk, rdata & note.msk);
      check("read response", note.resp, rresp);
    end
    if (bvalid) check("write response", bq.pop_front(), bresp);
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [1:0] er = rsbt_pkg::RESP_OKAY);
    int n = 0;
    bq.push_back(er);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do @(posedge sys_clk); while (!(awready && wready) && n++ < 50);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge sys_clk); while (!bvalid && n++ < 50);
    if (n > 50) n_mismatch++;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] k,
      input logic [1:0] er = rsbt_pkg::RESP_OKAY);
    int n = 0;
    rq.push_back(rsbt_note_t'{v, k, er});
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge sys_clk); while (!arready && n++ < 50);
    arvalid <= 1'h0;
    do @(posedge sys_clk); while (!rvalid && n++ < 50);
    if (n > 50) n_mismatch++;
    d = rdata;
  endtask

  // Polls status until the chosen bit reaches the wanted level.
  task automatic waitFor(input int b, input logic v);
    int n = 0;
    do rd(rsbt_pkg::REG_STATUS, 32'h0, 32'h0); while (d[b] !== v && n++ < 400);
    check("status wait", v, d[b]);
  endtask

  task automatic xfer(input logic [1:0] k, input logic sc);
    wr(rsbt_pkg::REG_ADDR, {7'h00, col, 7'h00, row});
    wr(rsbt_pkg::REG_MASK, {24'h0, m});
    wr(rsbt_pkg::REG_CTRL, {28'h0, sc, k, 1'h1});
  endtask

  // Hang guard.
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'h1;
    rd(rsbt_pkg::REG_STATUS, 32'h0, 32'h33);
    rd(rsbt_pkg::REG_CTRL, 32'h0, 32'hF);
    wstrb <= 4'hE;
    wr(rsbt_pkg::REG_CTRL, 32'h1);
    wstrb <= 4'hF;
    wr(rsbt_pkg::REG_CTRL, 32'h5);
    waitFor(0, 1'h0);
    check("split before normal", 0, dev.count);
    rd(rsbt_pkg::REG_STATUS, 32'h2, 32'h3);
    wr(rsbt_pkg::REG_CTRL, 32'h0);
    port = 1'h0;
    // Every kind, each followed by a start that arrives while busy.
    for (int k = 0; k < 4; k++) begin
      row = rs[8:0];
      col = rs[17:9];
      m = rs[25:18];
      rs = lfsr(rs);
      xfer(k[1:0], 1'h0);
      wr(rsbt_pkg::REG_CTRL, 32'h1);
      waitFor(0, 1'h0);
      if (k < 2) port = !k[0];
      if (k[0]) lvl = ~m;
      check("kind", k, dev.kind);
      check("row", row, dev.row);
      check("column", col, dev.col);
      check("words", k[1] ? 256 : 512, dev.words);
      if (k[0]) check("mask", m, dev.mask);
      check("port mode", port, dev.portOut);
      rd(rsbt_pkg::REG_STATUS, {16'h0, lvl, 2'h0, k[0], 1'h1, port, 3'h2}, 32'hFF3B);
      wr(rsbt_pkg::REG_CTRL, 32'h0);
    end
    // Serial clock running: half switch, real-time read, then write and read.
    col = {5'h0F, rs[3:0]};
    xfer(2'h0, 1'h1);
    waitFor(0, 1'h0);
    waitFor(2, 1'h1);
    check("half flag", 1, dev.halfActiveFlag);
    xfer(2'h0, 1'h1);
    waitFor(0, 1'h0);
    xfer(2'h1, 1'h1);
    waitFor(0, 1'h0);
    xfer(2'h0, 1'h1);
    waitFor(0, 1'h0);
    xfer(2'h2, 1'h1);
    waitFor(0, 1'h0);
    check("serial clock hazards", 0, dev.scBad);
    // A split write while the port is still in output mode is refused.
    xfer(2'h3, 1'h1);
    waitFor(0, 1'h0);
    rd(rsbt_pkg::REG_STATUS, 32'h2, 32'h3);
    wr(rsbt_pkg::REG_CTRL, 32'h0);
    check("transfer count", 9, dev.count);
    // Unmapped place and read-only status.
    wr(8'h10, 32'h1, rsbt_pkg::RESP_SLVERR);
    rd(8'h10, 32'h0, 32'hFFFFFFFF, rsbt_pkg::RESP_SLVERR);
    wr(rsbt_pkg::REG_ADDR, 32'h01230045);
    wr(rsbt_pkg::REG_STATUS, 32'h3F);
    rd(rsbt_pkg::REG_ADDR, 32'h01230045, 32'h01FF01FF);
    rd(rsbt_pkg::REG_STATUS, 32'h0, 32'h3);
    end_of_test();
  end
endmodule
